// ===== rtl/branch_compare_flag_exec.sv
// branch, call, compare and flag-clear execution slice
//
// Implementation choices: the strobed register port and the placing of the registers.
`include "branch_compare_flag_exec_params.svh"

module branch_compare_flag_exec
    import branch_compare_flag_exec_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic [31:0] instr_addr,
    input wire logic irq_pending,
    input wire logic gpr_wr_en,
    input wire logic [3:0] gpr_wr_sel,
    input wire logic [31:0] gpr_wr_data,
    input wire logic flag_wr_en,
    input wire logic cond_flag_in,
    input wire logic clip_flag_in,
    input wire logic accum_wr_en,
    input wire logic [31:0] accum_high_in,
    input wire logic [31:0] accum_low_in,
    output logic instr_ready,
    output logic done,
    output logic [31:0] next_pc,
    output logic pc_redirect,
    output logic slot_illegal,
    output logic foreign_instr,
    output logic irq_accept,
    output logic in_slot,
    output logic cond_flag,
    output logic clip_flag,
    output logic [31:0] accum_high,
    output logic [31:0] accum_low,
    output logic [31:0] return_link
);

    state_t st_q;
    state_t st_d;
    op_t op_q;
    op_t op_in;
    logic [15:0] instr_q;
    logic [31:0] addr_q;
    logic take;
    logic [3:0] sel_a;
    logic [31:0] dst_data;
    logic [31:0] src_data;
    logic slot_pend_q;
    logic [31:0] slot_tgt_q;
    logic instr_ready_q;
    logic done_q;
    logic [31:0] next_pc_q;
    logic pc_redirect_q;
    logic slot_illegal_q;
    logic foreign_q;
    logic irq_accept_q;
    logic cond_q;
    logic clip_q;
    logic [31:0] acc_hi_q;
    logic [31:0] acc_lo_q;
    logic [31:0] link_q;

    logic exec;
    logic is_branch;
    logic bad_slot;
    logic run;
    logic cmp_op;
    logic cmp_res;
    logic [31:0] link_val;
    logic [31:0] seq_pc;
    logic [31:0] tgt;
    logic opens_slot;
    logic [31:0] pc_d;
    logic redirect_d;
    logic finish;

    // sign-extend a displacement and double it
    function automatic logic [31:0] disp_x2(
        input logic [11:0] d,
        input logic wide
    );
        logic [31:0] s;
        s = 32'h0000_0000;
        if (wide) begin
            s = {{20{d[11]}}, d};
        end else begin
            s = {{24{d[7]}}, d[7:0]};
        end
        disp_x2 = {s[30:0], 1'b0};
    endfunction : disp_x2

    function automatic logic any_byte_eq(
        input logic [31:0] a,
        input logic [31:0] b
    );
        logic [31:0] x;
        x = a ^ b;
        any_byte_eq = (x[31:24] == 8'h00) || (x[23:16] == 8'h00) ||
            (x[15:8] == 8'h00) || (x[7:0] == 8'h00);
    endfunction : any_byte_eq

    function automatic logic compare(
        input op_t o,
        input logic [31:0] d,
        input logic [31:0] s,
        input logic [7:0] imm
    );
        logic r;
        r = 1'b0;
        case (o)
            OP_CMP_EQUAL: r = (d == s);
            OP_CMP_SIGNED_GE: r = ($signed(d) >= $signed(s));
            OP_CMP_SIGNED_GT: r = ($signed(d) > $signed(s));
            OP_CMP_UNSIGNED_ABOVE: r = (d > s);
            OP_CMP_UNSIGNED_AE: r = (d >= s);
            OP_CMP_POSITIVE: r = ($signed(d) > $signed(32'h0000_0000));
            OP_CMP_NONNEG: r = !d[31];
            OP_CMP_BYTE: r = any_byte_eq(d, s);
            OP_CMP_IMM: r = (d == {{24{imm[7]}}, imm});
            default: r = 1'b0;
        endcase
        compare = r;
    endfunction : compare

    // accept and read-address steering
    assign take = instr_valid && instr_ready_q;
    assign op_in = decode(instr_word);
    assign sel_a = (op_in == OP_CMP_IMM) ? 4'h0 :
        instr_word[`DST_MSB:`DST_LSB];

    gpr_file u_gpr (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .wr_en(gpr_wr_en),
        .wr_sel(gpr_wr_sel),
        .wr_data(gpr_wr_data),
        .rd_en(take),
        .rd_sel_a(sel_a),
        .rd_sel_b(instr_word[`SRC_MSB:`SRC_LSB]),
        .rd_data_a(dst_data),
        .rd_data_b(src_data)
    );

    // execute-stage decode
    assign exec = (st_q == ST_EXEC);
    assign is_branch = (op_q == OP_CALL_REL) || (op_q == OP_CALL_REG) ||
        (op_q == OP_JMP_SET) || (op_q == OP_JMP_SET_D);
    assign bad_slot = slot_pend_q && is_branch;
    assign run = exec && !bad_slot;
    assign cmp_op = (op_q >= OP_CMP_EQUAL);
    assign cmp_res = compare(op_q, dst_data, src_data, instr_q[7:0]);
    assign link_val = addr_q + `LINK_OFS;
    assign seq_pc = addr_q + `PC_STEP;

    always_comb begin
        tgt = 32'h0000_0000;
        case (op_q)
            OP_CALL_REL: tgt = link_val + disp_x2(instr_q[11:0], 1'b1);
            OP_CALL_REG: tgt = link_val + dst_data;
            OP_JMP_SET: tgt = link_val + disp_x2(instr_q[11:0], 1'b0);
            OP_JMP_SET_D: tgt = link_val + disp_x2(instr_q[11:0], 1'b0);
            default: tgt = seq_pc;
        endcase
    end

    // a delayed branch opens a slot; conditional only when taken
    always_comb begin
        opens_slot = 1'b0;
        case (op_q)
            OP_CALL_REL: opens_slot = 1'b1;
            OP_CALL_REG: opens_slot = 1'b1;
            OP_JMP_SET_D: opens_slot = cond_q;
            default: opens_slot = 1'b0;
        endcase
    end

    // next program counter
    always_comb begin
        pc_d = seq_pc;
        redirect_d = 1'b0;
        if (slot_pend_q) begin
            pc_d = slot_tgt_q;
            redirect_d = 1'b1;
        end else if (op_q == OP_JMP_SET && cond_q) begin
            pc_d = tgt;
            redirect_d = 1'b1;
        end
    end

    assign finish = (exec && !(run && op_q == OP_CALL_REG)) ||
        (st_q == ST_HOLD);

    // sequencer
    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_IDLE: begin
                if (take) begin
                    st_d = ST_EXEC;
                end
            end
            ST_EXEC: begin
                if (run && op_q == OP_CALL_REG) begin
                    st_d = ST_HOLD;
                end else begin
                    st_d = ST_IDLE;
                end
            end
            ST_HOLD: st_d = ST_IDLE;
            default: st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            st_q <= ST_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            instr_q <= 16'h0000;
            addr_q <= `PC_RST;
            op_q <= OP_NONE;
        end else if (take) begin
            instr_q <= instr_word;
            addr_q <= instr_addr;
            op_q <= op_in;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            instr_ready_q <= 1'b1;
        end else if (take) begin
            instr_ready_q <= 1'b0;
        end else if (finish) begin
            instr_ready_q <= 1'b1;
        end
    end

    // delay-slot tracking
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            slot_pend_q <= 1'b0;
            slot_tgt_q <= `PC_RST;
        end else if (exec) begin
            if (slot_pend_q) begin
                slot_pend_q <= 1'b0;
            end else if (opens_slot) begin
                slot_pend_q <= 1'b1;
                slot_tgt_q <= tgt;
            end
        end
    end

    // completion, pc and event pulses
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            done_q <= 1'b0;
            pc_redirect_q <= 1'b0;
            slot_illegal_q <= 1'b0;
            foreign_q <= 1'b0;
            irq_accept_q <= 1'b0;
        end else begin
            done_q <= finish;
            pc_redirect_q <= exec && redirect_d && !bad_slot;
            slot_illegal_q <= exec && bad_slot;
            foreign_q <= exec && (op_q == OP_NONE);
            irq_accept_q <= exec && irq_pending &&
                (slot_pend_q || !opens_slot);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            next_pc_q <= `PC_RST;
        end else if (run) begin
            next_pc_q <= pc_d;
        end
    end

    // condition flag
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            cond_q <= `COND_RST;
        end else if (run && op_q == OP_ZERO_COND) begin
            cond_q <= 1'b0;
        end else if (run && cmp_op) begin
            cond_q <= cmp_res;
        end else if (flag_wr_en && !exec) begin
            cond_q <= cond_flag_in;
        end
    end

    // saturation flag
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            clip_q <= `CLIP_RST;
        end else if (run && op_q == OP_ZERO_CLIP) begin
            clip_q <= 1'b0;
        end else if (flag_wr_en && !exec) begin
            clip_q <= clip_flag_in;
        end
    end

    // accumulator pair
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            acc_hi_q <= `ACC_RST;
            acc_lo_q <= `ACC_RST;
        end else if (run && op_q == OP_ZERO_ACC) begin
            acc_hi_q <= `ACC_RST;
            acc_lo_q <= `ACC_RST;
        end else if (accum_wr_en && !exec) begin
            acc_hi_q <= accum_high_in;
            acc_lo_q <= accum_low_in;
        end
    end

    // return link for both call forms
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            link_q <= `LINK_RST;
        end else if (run && (op_q == OP_CALL_REL || op_q == OP_CALL_REG))
        begin
            link_q <= link_val;
        end
    end

    assign instr_ready = instr_ready_q;
    assign done = done_q;
    assign next_pc = next_pc_q;
    assign pc_redirect = pc_redirect_q;
    assign slot_illegal = slot_illegal_q;
    assign foreign_instr = foreign_q;
    assign irq_accept = irq_accept_q;
    assign in_slot = slot_pend_q;
    assign cond_flag = cond_q;
    assign clip_flag = clip_q;
    assign accum_high = acc_hi_q;
    assign accum_low = acc_lo_q;
    assign return_link = link_q;

endmodule : branch_compare_flag_exec

// ===== rtl/branch_compare_flag_exec_params.svh
// constants for the branch, compare and flag execution slice
`ifndef BRANCH_COMPARE_FLAG_EXEC_PARAMS_SVH
`define BRANCH_COMPARE_FLAG_EXEC_PARAMS_SVH

`define INSN_W 16
`define WORD_W 32
`define GPR_SEL_W 4
`define GPR_COUNT 16

`define PC_STEP 32'h0000_0002
`define LINK_OFS 32'h0000_0004

`define COND_RST 1'b0
`define CLIP_RST 1'b0
`define ACC_RST 32'h0000_0000
`define LINK_RST 32'h0000_0000
`define PC_RST 32'h0000_0000

`define CALL_REG_STATES 2

`define DST_MSB 11
`define DST_LSB 8
`define SRC_MSB 7
`define SRC_LSB 4
`define DISP12_MSB 11
`define DISP8_MSB 7

`define M_CALL_REL 16'hF000
`define V_CALL_REL 16'hB000
`define M_CALL_REG 16'hF0FF
`define V_CALL_REG 16'h0003
`define M_JMP_SET 16'hFF00
`define V_JMP_SET 16'h8900
`define M_JMP_SET_D 16'hFF00
`define V_JMP_SET_D 16'h8D00
`define M_FULL 16'hFFFF
`define V_ZERO_ACC 16'h0028
`define V_ZERO_CLIP 16'h0048
`define V_ZERO_COND 16'h0008
`define M_CMP_RR 16'hF00F
`define V_CMP_EQUAL 16'h3000
`define V_CMP_SIGNED_GE 16'h3003
`define V_CMP_SIGNED_GT 16'h3007
`define V_CMP_UNSIGNED_ABOVE 16'h3006
`define V_CMP_UNSIGNED_AE 16'h3002
`define V_CMP_BYTE 16'h200C
`define M_CMP_R 16'hF0FF
`define V_CMP_POSITIVE 16'h4015
`define V_CMP_NONNEG 16'h4011
`define M_CMP_IMM 16'hFF00
`define V_CMP_IMM 16'h8800

`endif

// ===== rtl/branch_compare_flag_exec_pkg.sv
// types and decoder for the branch, compare and flag slice
`include "branch_compare_flag_exec_params.svh"

package branch_compare_flag_exec_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_EXEC,
        ST_HOLD
    } state_t;

    typedef enum logic [4:0] {
        OP_NONE,
        OP_CALL_REL,
        OP_CALL_REG,
        OP_JMP_SET,
        OP_JMP_SET_D,
        OP_ZERO_ACC,
        OP_ZERO_CLIP,
        OP_ZERO_COND,
        OP_CMP_EQUAL,
        OP_CMP_SIGNED_GE,
        OP_CMP_SIGNED_GT,
        OP_CMP_UNSIGNED_ABOVE,
        OP_CMP_UNSIGNED_AE,
        OP_CMP_POSITIVE,
        OP_CMP_NONNEG,
        OP_CMP_BYTE,
        OP_CMP_IMM
    } op_t;

    function automatic logic hit(
        input logic [15:0] w,
        input logic [15:0] m,
        input logic [15:0] v
    );
        hit = ((w & m) == v);
    endfunction : hit

    function automatic op_t decode(input logic [15:0] w);
        op_t o;
        o = OP_NONE;
        if (hit(w, `M_CALL_REL, `V_CALL_REL)) o = OP_CALL_REL;
        else if (hit(w, `M_CALL_REG, `V_CALL_REG)) o = OP_CALL_REG;
        else if (hit(w, `M_JMP_SET, `V_JMP_SET)) o = OP_JMP_SET;
        else if (hit(w, `M_JMP_SET_D, `V_JMP_SET_D)) o = OP_JMP_SET_D;
        else if (hit(w, `M_FULL, `V_ZERO_ACC)) o = OP_ZERO_ACC;
        else if (hit(w, `M_FULL, `V_ZERO_CLIP)) o = OP_ZERO_CLIP;
        else if (hit(w, `M_FULL, `V_ZERO_COND)) o = OP_ZERO_COND;
        else if (hit(w, `M_CMP_RR, `V_CMP_EQUAL)) o = OP_CMP_EQUAL;
        else if (hit(w, `M_CMP_RR, `V_CMP_SIGNED_GE)) o = OP_CMP_SIGNED_GE;
        else if (hit(w, `M_CMP_RR, `V_CMP_SIGNED_GT)) o = OP_CMP_SIGNED_GT;
        else if (hit(w, `M_CMP_RR, `V_CMP_UNSIGNED_ABOVE)) o = OP_CMP_UNSIGNED_ABOVE;
        else if (hit(w, `M_CMP_RR, `V_CMP_UNSIGNED_AE)) o = OP_CMP_UNSIGNED_AE;
        else if (hit(w, `M_CMP_R, `V_CMP_POSITIVE)) o = OP_CMP_POSITIVE;
        else if (hit(w, `M_CMP_R, `V_CMP_NONNEG)) o = OP_CMP_NONNEG;
        else if (hit(w, `M_CMP_RR, `V_CMP_BYTE)) o = OP_CMP_BYTE;
        else if (hit(w, `M_CMP_IMM, `V_CMP_IMM)) o = OP_CMP_IMM;
        decode = o;
    endfunction : decode

endpackage : branch_compare_flag_exec_pkg

// ===== rtl/gpr_file.sv
// general register file, one write port, two registered read ports
`include "branch_compare_flag_exec_params.svh"

module gpr_file (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic wr_en,
    input wire logic [3:0] wr_sel,
    input wire logic [31:0] wr_data,
    input wire logic rd_en,
    input wire logic [3:0] rd_sel_a,
    input wire logic [3:0] rd_sel_b,
    output logic [31:0] rd_data_a,
    output logic [31:0] rd_data_b
);
    logic [31:0] mem [0:`GPR_COUNT-1];

    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_sel] <= wr_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rd_data_a <= 32'h0000_0000;
            rd_data_b <= 32'h0000_0000;
        end else if (rd_en) begin
            rd_data_a <= mem[rd_sel_a];
            rd_data_b <= mem[rd_sel_b];
        end
    end
endmodule : gpr_file

// ===== tb/branch_compare_flag_exec_properties.sv
// assertion checker for the branch, compare and flag slice
module branch_compare_flag_exec_properties (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic [31:0] instr_addr,
    input wire logic flag_wr_en,
    input wire logic instr_ready,
    input wire logic done,
    input wire logic [31:0] next_pc,
    input wire logic pc_redirect,
    input wire logic slot_illegal,
    input wire logic irq_accept,
    input wire logic in_slot,
    input wire logic cond_flag,
    input wire logic clip_flag,
    input wire logic [31:0] accum_high,
    input wire logic [31:0] accum_low,
    input wire logic [31:0] return_link
);
    timeunit 1ns;
    timeprecision 1ps;
    logic tk;
    logic cr;
    logic jmp;
    logic [31:0] d8;
    assign tk = instr_valid && instr_ready;
    assign cr = ((instr_word & 16'hF0FF) == 16'h0003) && !in_slot;
    assign jmp = tk && instr_word[15:8] == 8'h89 && !in_slot && !flag_wr_en;
    assign d8 = {{23{instr_word[7]}}, instr_word[7:0], 1'b0};
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    property p_call_reg;
        tk && cr |-> ##1 !done [*2] ##1 done;
    endproperty
    a_call_reg: assert property (p_call_reg)
        else $error("register call not done in three cycles");
    property p_one_state;
        tk && !cr |-> ##1 !done ##1 done;
    endproperty
    a_one_state: assert property (p_one_state)
        else $error("instruction not done in two cycles");
    property p_zero_cond;
        tk && instr_word == 16'h0008 |-> ##2 !cond_flag;
    endproperty
    a_zero_cond: assert property (p_zero_cond)
        else $error("condition flag not cleared");
    property p_zero_accum;
        tk && instr_word == 16'h0028 |-> ##2 accum_high == 32'h0000_0000
            && accum_low == 32'h0000_0000;
    endproperty
    a_zero_accum: assert property (p_zero_accum)
        else $error("accumulator not cleared");
    property p_zero_clip;
        tk && instr_word == 16'h0048 |-> ##2 !clip_flag;
    endproperty
    a_zero_clip: assert property (p_zero_clip)
        else $error("clip flag not cleared");
    property p_jump_taken;
        jmp && cond_flag |-> ##2 pc_redirect
            && next_pc == $past(instr_addr, 2) + 32'h0000_0004 + $past(d8, 2);
    endproperty
    a_jump_taken: assert property (p_jump_taken)
        else $error("taken jump target wrong");
    property p_jump_fall;
        jmp && !cond_flag |-> ##2 !pc_redirect
            && next_pc == $past(instr_addr, 2) + 32'h0000_0002;
    endproperty
    a_jump_fall: assert property (p_jump_fall)
        else $error("untaken jump did not fall through");
    property p_call_link;
        tk && instr_word[15:12] == 4'hB && !in_slot |-> ##2 in_slot
            && return_link == $past(instr_addr, 2) + 32'h0000_0004;
    endproperty
    a_call_link: assert property (p_call_link)
        else $error("call link or slot wrong");
    property p_irq_hold;
        tk && instr_word[15:12] == 4'hB && !in_slot |-> ##2 !irq_accept;
    endproperty
    a_irq_hold: assert property (p_irq_hold)
        else $error("interrupt accepted before slot");
    property p_slot_illegal;
        tk && in_slot && (instr_word[15:12] == 4'hB
            || instr_word[15:8] == 8'h89) |-> ##2 slot_illegal && !in_slot;
    endproperty
    a_slot_illegal: assert property (p_slot_illegal)
        else $error("branch in slot not flagged");
    property p_cmp_same;
        tk && instr_word[15:12] == 4'h3 && instr_word[3:0] == 4'h0
            && instr_word[11:8] == instr_word[7:4] |-> ##2 cond_flag;
    endproperty
    a_cmp_same: assert property (p_cmp_same)
        else $error("equal compare of one register not set");
endmodule : branch_compare_flag_exec_properties

bind branch_compare_flag_exec branch_compare_flag_exec_properties props_inst (
    .sys_clk(sys_clk), .nrst(nrst), .instr_valid(instr_valid),
    .instr_word(instr_word), .instr_addr(instr_addr),
    .flag_wr_en(flag_wr_en), .instr_ready(instr_ready), .done(done),
    .next_pc(next_pc), .pc_redirect(pc_redirect),
    .slot_illegal(slot_illegal), .irq_accept(irq_accept),
    .in_slot(in_slot), .cond_flag(cond_flag), .clip_flag(clip_flag),
    .accum_high(accum_high), .accum_low(accum_low),
    .return_link(return_link)
);

// ===== tb/fetch_model.sv
// fetch side model: offers one instruction per request, then releases
module fetch_model (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic go,
    input wire logic [15:0] word_in,
    input wire logic [31:0] addr_in,
    input wire logic instr_ready,
    output logic instr_valid,
    output logic [15:0] instr_word,
    output logic [31:0] instr_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            instr_valid <= 1'b0;
            instr_word <= 16'h0000;
            instr_addr <= 32'h0000_0000;
        end else if (go) begin
            instr_valid <= 1'b1;
            instr_word <= word_in;
            instr_addr <= addr_in;
        end else if (instr_valid && instr_ready) begin
            instr_valid <= 1'b0;
            instr_word <= ~instr_word;
            instr_addr <= ~instr_addr;
        end
    end
endmodule : fetch_model

// ===== tb/branch_compare_flag_exec_test.sv
// testbench for the branch, compare and flag slice
module branch_compare_flag_exec_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, nrst, go, instr_valid, irq_pending, gpr_wr_en;
    logic flag_wr_en, cond_flag_in, clip_flag_in, accum_wr_en, instr_ready;
    logic done, pc_redirect, slot_illegal, foreign_instr, irq_accept;
    logic in_slot, cond_flag, clip_flag;
    logic [15:0] instr_word, word_in;
    logic [3:0] gpr_wr_sel;
    logic [31:0] instr_addr, addr_in, gpr_wr_data, accum_high_in;
    logic [31:0] accum_low_in, next_pc, accum_high, accum_low, return_link;
    int bad_count = 0;
    int comparisons = 0;
    localparam logic [15:0] CW [20] = '{16'h3110, 16'h3120, 16'h3213,
        16'h3123, 16'h3217, 16'h3117, 16'h3126, 16'h3116, 16'h3112,
        16'h3212, 16'h4215, 16'h4115, 16'h4311, 16'h4315, 16'h254C,
        16'h212C, 16'h8880, 16'h887F, 16'h4211, 16'h4111};

    branch_compare_flag_exec branch_compare_flag_exec_inst (.*);
    fetch_model fetch_model_inst (.*);

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic tally_and_finish();
        if (bad_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic gw(input logic [3:0] s, input logic [31:0] d);
        @(posedge sys_clk);
        gpr_wr_en <= 1'b1;
        gpr_wr_sel <= s;
        gpr_wr_data <= d;
        @(posedge sys_clk);
        gpr_wr_en <= 1'b0;
    endtask : gw

    task automatic ld(input logic c, input logic s, input logic [31:0] h);
        @(posedge sys_clk);
        flag_wr_en <= 1'b1;
        accum_wr_en <= 1'b1;
        cond_flag_in <= c;
        clip_flag_in <= s;
        accum_high_in <= h;
        accum_low_in <= ~h;
        @(posedge sys_clk);
        flag_wr_en <= 1'b0;
        accum_wr_en <= 1'b0;
    endtask : ld

    task automatic run(input logic [15:0] w, input logic [31:0] a,
                       input int lat);
        int n;
        n = 1;
        @(posedge sys_clk);
        go <= 1'b1;
        word_in <= w;
        addr_in <= a;
        do begin
            @(posedge sys_clk);
            go <= 1'b0;
            #1;
            n++;
        end while (done !== 1'b1 && n < 12);
        chk(n, lat);
    endtask : run

    initial begin
        repeat (3000) @(posedge sys_clk);
        bad_count++;
        tally_and_finish();
    end

    initial begin
        logic [31:0] a;
        {nrst, go, irq_pending, gpr_wr_en, flag_wr_en} = '0;
        {cond_flag_in, clip_flag_in, accum_wr_en, gpr_wr_sel} = '0;
        {word_in, addr_in, gpr_wr_data, accum_high_in, accum_low_in} = '0;
        repeat (5) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        #1;
        chk({instr_ready, in_slot, cond_flag, clip_flag, done}, 5'b10000);
        chk(accum_high | accum_low | return_link | next_pc, 0);
        gw(0, 32'hFFFF_FF80);
        gw(1, 32'h8000_0000);
        gw(2, 32'h7FFF_FFFF);
        gw(3, 32'h0000_0000);
        gw(4, 32'h4142_4344);
        gw(5, 32'h5859_435A);
        gw(6, 32'h0000_0100);
        for (int i = 0; i < 20; i++) begin
            a = 32'h0000_0400 + 32'(2 * i);
            run(CW[i], a, 2 + 2);
            chk({cond_flag, next_pc}, {!i[0], a + 32'h2});
        end
        ld(1'b1, 1'b1, 32'h1234_5678);
        run(16'h0028, 32'h0000_0500, 4);
        chk({cond_flag, accum_high | accum_low}, {1'b1, 32'h0});
        run(16'h0048, 32'h0000_0502, 4);
        chk({cond_flag, clip_flag}, 2'b10);
        run(16'h0008, 32'h0000_0504, 4);
        chk({cond_flag, next_pc}, {1'b0, 32'h0000_0506});
        run(16'h8905, 32'h0000_0600, 4);
        chk({pc_redirect, next_pc}, {1'b0, 32'h0000_0602});
        ld(1'b1, 1'b0, 32'h0000_0000);
        run(16'h89FE, 32'h0000_0600, 4);
        chk({pc_redirect, next_pc}, {1'b1, 32'h0000_0600});
        run(16'h897F, 32'h0000_0600, 4);
        chk({pc_redirect, next_pc}, {1'b1, 32'h0000_0702});
        run(16'h8980, 32'h0000_0600, 4);
        chk({pc_redirect, next_pc}, {1'b1, 32'h0000_0504});
        irq_pending <= 1'b1;
        run(16'h8D10, 32'h0000_0700, 4);
        chk({in_slot, irq_accept}, 2'b10);
        run(16'h0008, 32'h0000_0702, 4);
        chk({pc_redirect, irq_accept, in_slot, cond_flag, next_pc},
            {4'b1100, 32'h0000_0724});
        run(16'h8D10, 32'h0000_0800, 4);
        chk({in_slot, pc_redirect, next_pc}, {2'b00, 32'h0000_0802});
        run(16'hB7FF, 32'h0000_2000, 4);
        chk({in_slot, return_link}, {1'b1, 32'h0000_2004});
        run(16'h3110, 32'h0000_2002, 4);
        chk({pc_redirect, cond_flag, next_pc}, {2'b11, 32'h0000_3002});
        run(16'hB800, 32'h0000_1000, 4);
        chk({in_slot, return_link}, {1'b1, 32'h0000_1004});
        run(16'h3110, 32'h0000_1002, 4);
        chk({pc_redirect, next_pc}, {1'b1, 32'h0000_0004});
        run(16'hB800, 32'h0000_1000, 4);
        run(16'h8900, 32'h0000_1002, 4);
        chk({slot_illegal, in_slot}, 2'b10);
        run(16'h0603, 32'h0000_3000, 5);
        chk({in_slot, return_link}, {1'b1, 32'h0000_3004});
        run(16'h0008, 32'h0000_3002, 4);
        chk({pc_redirect, next_pc}, {1'b1, 32'h0000_3104});
        run(16'h6123, 32'h0000_4000, 4);
        chk({foreign_instr, next_pc}, {1'b1, 32'h0000_4002});
        tally_and_finish();
    end
endmodule : branch_compare_flag_exec_test
